// >>> rtl/eeprom_host_pkg.sv
// Constants for the parallel EEPROM host controller
package eeprom_host_pkg;
   localparam int ADDR_W       = 13;
   localparam int DATA_W       = 8;
   localparam int PAGE_BYTES   = 32;
   localparam int PAGE_LSB_W   = 5;
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_STROBE_NS  = 200;
   localparam int T_SETUP_NS   = 100;
   localparam int T_HOLD_NS    = 150;
   localparam int T_READ_NS    = 250;
   localparam int T_LOAD_MAX_US = 30;
   localparam int T_WSTART_NS  = 150;
   localparam int T_WRITE_MS   = 10;
   localparam int T_LOCK_US    = 1;
   // Least times and waits round up, only the longest load gap rounds down
   localparam int STROBE_CYC   = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC    = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC     = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC     = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int LOAD_MAX_CYC = (T_LOAD_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int WSTART_CYC   = (T_WSTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYC    = (T_WRITE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_CYC     = (T_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W        = 21;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 13'h0000;

   typedef enum logic [6:0] {
      ST_LOCK  = 7'h01,
      ST_IDLE  = 7'h02,
      ST_RSET  = 7'h04,
      ST_RDATA = 7'h08,
      ST_WLOW  = 7'h10,
      ST_WHIGH = 7'h20,
      ST_WAIT  = 7'h40
   } host_state_e;
endpackage : eeprom_host_pkg

// >>> rtl/eeprom_host.sv
// Host controller driving a byte-wide page-write EEPROM over its pins
`timescale 1ns/1ps
`default_nettype none
module eeprom_host #(
   parameter int WRITE_CYC = eeprom_host_pkg::WRITE_CYC
) (
   // Clock and reset
   input  wire logic                                 clock_i,
   input  wire logic                                 rst_n_i,
   // User request port
   input  wire logic                                 req_valid_i,
   input  wire logic                                 req_write_i,
   input  wire logic                                 req_last_i,
   input  wire logic [eeprom_host_pkg::ADDR_W-1:0]   req_addr_i,
   input  wire logic [eeprom_host_pkg::DATA_W-1:0]   req_data_i,
   output logic                                      req_ready_o,
   output logic                                      rd_valid_o,
   output logic [eeprom_host_pkg::DATA_W-1:0]        rd_data_o,
   output logic                                      busy_o,
   output logic                                      page_err_o,
   // Device pins
   output logic [eeprom_host_pkg::ADDR_W-1:0]        word_select_bus_o,
   input  wire logic [eeprom_host_pkg::DATA_W-1:0]   byte_lane_bus_i,
   output logic [eeprom_host_pkg::DATA_W-1:0]        byte_lane_bus_o,
   output logic                                      byte_lane_bus_oe_n_o,
   output logic                                      chip_en_n_o,
   output logic                                      out_en_n_o,
   output logic                                      write_strobe_n_o,
   output logic                                      write_lock_n_o,
   input  wire logic                                 write_pending_n_i
);
   page_size_check : assert final (eeprom_host_pkg::PAGE_BYTES == (1 << eeprom_host_pkg::PAGE_LSB_W))
      else $error("page size and page field width disagree");

   localparam int CW = eeprom_host_pkg::CNT_W;

   if (WRITE_CYC < 1 || WRITE_CYC >= (1 << CW)) begin : g_bad_param
      $error("WRITE_CYC out of range");
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [CW-1:0] cyc(input int n);
      return CW'(n);
   endfunction : cyc

   function automatic logic same_page(input logic [eeprom_host_pkg::ADDR_W-1:0] a,
                                      input logic [eeprom_host_pkg::ADDR_W-1:0] b);
      return a[eeprom_host_pkg::ADDR_W-1:eeprom_host_pkg::PAGE_LSB_W]
             == b[eeprom_host_pkg::ADDR_W-1:eeprom_host_pkg::PAGE_LSB_W];
   endfunction : same_page

   eeprom_host_pkg::host_state_e state_reg;
   logic [CW-1:0]                 cnt_reg;
   logic [CW-1:0]                 gap_reg;
   logic [5:0]                    nbytes_reg;
   logic [eeprom_host_pkg::ADDR_W-1:0] page_reg;
   logic                          last_reg;
   logic                          poll_reg;
   logic                          top_bit_reg;
   logic                          accept;

   assign accept = req_valid_i && req_ready_o;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_reg <= eeprom_host_pkg::ST_LOCK;
         cnt_reg   <= '0;
      end else begin
         unique case (state_reg)
            // lock held from reset, then kept high
            eeprom_host_pkg::ST_LOCK: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg >= cyc(eeprom_host_pkg::LOCK_CYC)) begin
                  state_reg <= eeprom_host_pkg::ST_IDLE;
                  cnt_reg   <= '0;
               end
            end
            eeprom_host_pkg::ST_IDLE: begin
               cnt_reg <= '0;
               if (accept && req_write_i) begin
                  state_reg <= eeprom_host_pkg::ST_WLOW;
               end else if (accept) begin
                  state_reg <= eeprom_host_pkg::ST_RSET;
               end else if (nbytes_reg != 6'h00 && gap_reg >= cyc(eeprom_host_pkg::HOLD_CYC)) begin
                  // page closes once the host stops loading
                  state_reg <= eeprom_host_pkg::ST_WAIT;
               end
            end
            eeprom_host_pkg::ST_RSET: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg >= cyc(eeprom_host_pkg::READ_CYC)) begin
                  state_reg <= eeprom_host_pkg::ST_RDATA;
               end
            end
            eeprom_host_pkg::ST_RDATA: begin
               cnt_reg   <= '0;
               state_reg <= eeprom_host_pkg::ST_IDLE;
            end
            // strobe low well beyond the noise filter width
            eeprom_host_pkg::ST_WLOW: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg >= cyc(eeprom_host_pkg::STROBE_CYC)) begin
                  state_reg <= eeprom_host_pkg::ST_WHIGH;
                  cnt_reg   <= '0;
               end
            end
            eeprom_host_pkg::ST_WHIGH: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg >= cyc(eeprom_host_pkg::HOLD_CYC)) begin
                  state_reg <= last_reg ? eeprom_host_pkg::ST_WAIT : eeprom_host_pkg::ST_IDLE;
                  cnt_reg   <= '0;
               end
            end
            // wait for end of internal write
            eeprom_host_pkg::ST_WAIT: begin
               cnt_reg <= cnt_reg + 1'b1;
               if ((poll_reg && cnt_reg >= cyc(eeprom_host_pkg::WSTART_CYC)
                    && write_pending_n_i) || cnt_reg >= cyc(WRITE_CYC)) begin
                  state_reg <= eeprom_host_pkg::ST_IDLE;
                  cnt_reg   <= '0;
               end
            end
            default: begin
               state_reg <= eeprom_host_pkg::ST_LOCK;
               cnt_reg   <= '0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Page bookkeeping
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         nbytes_reg <= 6'h00;
         page_reg   <= eeprom_host_pkg::ADDR_ZERO;
         last_reg   <= 1'b0;
         gap_reg    <= '0;
         page_err_o <= 1'b0;
         poll_reg   <= 1'b0;
      end else begin
         if (state_reg == eeprom_host_pkg::ST_WAIT) begin
            nbytes_reg <= 6'h00;
            gap_reg    <= '0;
            poll_reg   <= 1'b0;
         end else if (accept && req_write_i) begin
            // count loads, flag a page crossing
            nbytes_reg <= nbytes_reg + 6'h01;
            page_reg   <= req_addr_i;
            last_reg   <= req_last_i || nbytes_reg == 6'(eeprom_host_pkg::PAGE_BYTES - 1);
            gap_reg    <= '0;
            page_err_o <= nbytes_reg != 6'h00 && !same_page(page_reg, req_addr_i);
         end else if (nbytes_reg != 6'h00 && state_reg == eeprom_host_pkg::ST_IDLE) begin
            // idle gap timer; strobe time must not count or every page shuts at once
            gap_reg <= gap_reg + 1'b1;
         end
         if (state_reg == eeprom_host_pkg::ST_WHIGH && last_reg) begin
            poll_reg <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         word_select_bus_o    <= eeprom_host_pkg::ADDR_ZERO;
         byte_lane_bus_o      <= eeprom_host_pkg::DATA_ZERO;
         byte_lane_bus_oe_n_o <= 1'b1;
         chip_en_n_o          <= 1'b1;
         out_en_n_o           <= 1'b1;
         write_strobe_n_o     <= 1'b1;
         write_lock_n_o       <= 1'b0;
         rd_valid_o           <= 1'b0;
         rd_data_o            <= eeprom_host_pkg::DATA_ZERO;
         top_bit_reg          <= 1'b0;
      end else begin
         write_lock_n_o <= state_reg != eeprom_host_pkg::ST_LOCK;
         rd_valid_o     <= 1'b0;
         if (accept) begin
            word_select_bus_o <= req_addr_i;
            byte_lane_bus_o   <= req_data_i;
            if (req_write_i) begin
               top_bit_reg <= req_data_i[eeprom_host_pkg::DATA_W-1];
            end
         end
         // load with output enable high, strobe edges frame data
         chip_en_n_o          <= !(state_reg == eeprom_host_pkg::ST_WLOW
                                   || state_reg == eeprom_host_pkg::ST_RSET);
         write_strobe_n_o     <= state_reg != eeprom_host_pkg::ST_WLOW;
         out_en_n_o           <= state_reg != eeprom_host_pkg::ST_RSET;
         byte_lane_bus_oe_n_o <= !(state_reg == eeprom_host_pkg::ST_WLOW
                                   || state_reg == eeprom_host_pkg::ST_WHIGH);
         if (state_reg == eeprom_host_pkg::ST_RDATA) begin
            rd_valid_o <= 1'b1;
            rd_data_o  <= byte_lane_bus_i;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         req_ready_o <= 1'b0;
         busy_o      <= 1'b1;
      end else begin
         req_ready_o <= state_reg == eeprom_host_pkg::ST_IDLE && !accept
                        && !(nbytes_reg != 6'h00 && gap_reg >= cyc(eeprom_host_pkg::HOLD_CYC));
         busy_o      <= state_reg == eeprom_host_pkg::ST_WAIT
                        || state_reg == eeprom_host_pkg::ST_LOCK;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   lock_hold_a : assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_reg == eeprom_host_pkg::ST_WAIT) |=> write_lock_n_o)
      else $error("lock dropped during internal write");
   read_lock_a : assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !out_en_n_o |-> write_lock_n_o)
      else $error("read with lock low");
   strobe_width_a : assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $fell(write_strobe_n_o) |=> !write_strobe_n_o [*8])
      else $error("write strobe too short");
   load_oe_a : assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !write_strobe_n_o |-> out_en_n_o && !chip_en_n_o && !byte_lane_bus_oe_n_o)
      else $error("byte load with bad controls");
   gap_limit_a : assert property (@(posedge clock_i) disable iff (!rst_n_i)
      gap_reg <= cyc(eeprom_host_pkg::LOAD_MAX_CYC))
      else $error("page load gap too long");
   count_limit_a : assert property (@(posedge clock_i) disable iff (!rst_n_i)
      nbytes_reg <= 6'(eeprom_host_pkg::PAGE_BYTES))
      else $error("page over 32 bytes");
   data_hold_a : assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(write_strobe_n_o) |-> !byte_lane_bus_oe_n_o && $stable(byte_lane_bus_o))
      else $error("data not held at strobe rise");
   wstart_a : assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(busy_o) && write_lock_n_o |=> busy_o [*8])
      else $error("access before write start time");
endmodule : eeprom_host
`default_nettype wire

// >>> verif/eeprom_device_model.sv
// Behavioural page-write EEPROM driven from its pins
`timescale 1ns/1ps
`default_nettype none
module eeprom_device_model #(
   parameter int WINDOW_NS = 1000,
   parameter int PROG_NS   = 500
) (
   // Device pins
   input  wire logic [12:0] addr_i,
   input  wire logic [7:0]  data_i,
   output logic [7:0]       data_o,
   output logic             drive_o,
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        lock_n_i,
   output wire logic        pending_n_o
);
   logic [7:0]  mem [0:8191];
   logic [12:0] qa [$];
   logic [7:0]  qd [$];
   logic [12:0] a_lat;
   logic [7:0]  last_d = 8'hff;
   logic        prog   = 1'b0;
   logic        pend   = 1'b0;
   logic        armed  = 1'b0;
   realtime     t_fall;
   int          nq     = 0;
   int          n;
   initial for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
   assign pending_n_o = pend ? 1'b0 : 1'bz;
   assign drive_o = !ce_n_i && !oe_n_i && we_n_i && lock_n_i;
   assign data_o = prog ? {~last_d[7], mem[addr_i][6:0]} : mem[addr_i];
   always @(negedge we_n_i) begin
      // Let the other strobes of the same edge settle first
      #1;
      armed = !ce_n_i && oe_n_i && lock_n_i && !prog && nq < 32;
      a_lat = addr_i;
      t_fall = $realtime;
   end
   // data on strobe rise, short pulses ignored
   always @(posedge we_n_i) if (armed && $realtime - t_fall > 20) begin
      qa.push_back(a_lat);
      qd.push_back(data_i);
      last_d = data_i;
      nq = nq + 1;
      pend = 1'b1;
      armed = 1'b0;
   end
   // quiet window, timed program, lock low aborts
   initial forever begin
      wait (nq > 0);
      do begin
         n = nq;
         #(WINDOW_NS);
      end while (nq != n);
      prog = 1'b1;
      repeat (PROG_NS / 10) begin
         #10;
         if (!lock_n_i) n = 0;
      end
      for (int i = 0; i < n; i++) mem[qa[i]] = qd[i];
      qa.delete();
      qd.delete();
      nq = 0;
      prog = 1'b0;
      pend = 1'b0;
   end
endmodule : eeprom_device_model
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the EEPROM host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clock_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0;
   logic        req_write_i = 1'b0, req_last_i = 1'b0;
   logic [12:0] req_addr_i = 13'h0000, wsel;
   logic [7:0]  req_data_i = 8'h00, float_pat = 8'h00, rd_data_o, host_d, dev_d;
   logic        req_ready_o, rd_valid_o, busy_o, page_err_o, bus_oe_n, ce_n, oe_n;
   logic        we_n, lock_n, dev_drive;
   tri1         pend_n;
   int          n_mismatch = 0, n_compared = 0;
   // Undriven lane shows a moving pattern, never the last value
   wire [7:0]   lane = !bus_oe_n ? host_d : dev_drive ? dev_d : float_pat;
   initial forever #5 clock_i = ~clock_i;
   always @(posedge clock_i) float_pat <= float_pat + 8'h3b;
   eeprom_host #(.WRITE_CYC(200)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_last_i(req_last_i),
      .req_addr_i(req_addr_i), .req_data_i(req_data_i), .req_ready_o(req_ready_o),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .busy_o(busy_o),
      .page_err_o(page_err_o), .word_select_bus_o(wsel), .byte_lane_bus_i(lane),
      .byte_lane_bus_o(host_d), .byte_lane_bus_oe_n_o(bus_oe_n), .chip_en_n_o(ce_n),
      .out_en_n_o(oe_n), .write_strobe_n_o(we_n), .write_lock_n_o(lock_n),
      .write_pending_n_i(pend_n));
   eeprom_device_model dev (.addr_i(wsel), .data_i(lane), .data_o(dev_d),
      .drive_o(dev_drive), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .lock_n_i(lock_n), .pending_n_o(pend_n));

   task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic test_done;
      if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic issue(input logic wr, input logic last, input logic [12:0] a,
                        input logic [7:0] d);
      int k;
      k = 0;
      // Request stands until the edge that samples ready high
      @(posedge clock_i);
      req_valid_i <= 1'b1;
      req_write_i <= wr;
      req_last_i  <= last;
      req_addr_i  <= a;
      req_data_i  <= d;
      #1;
      while (req_ready_o !== 1'b1 && k < 3000) begin
         @(posedge clock_i);
         #1;
         k++;
      end
      if (k == 3000) check("ready_wait", 13'h0000, 13'h0001);
      @(posedge clock_i);
      req_valid_i <= 1'b0;
   endtask : issue
   task automatic read_chk(input logic [12:0] a, input logic [7:0] exp);
      int k;
      issue(1'b0, 1'b0, a, 8'h00);
      k = 0;
      while (rd_valid_o !== 1'b1 && k < 200) begin
         @(posedge clock_i);
         #1;
         k++;
      end
      check("read_valid", {12'h000, rd_valid_o}, 13'h0001);
      check("read_data", {5'h00, rd_data_o}, {5'h00, exp});
      check("lock_in_read", {12'h000, lock_n}, 13'h0001);
   endtask : read_chk
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic t_reset;
      check("lock_after_reset", {12'h000, lock_n}, 13'h0000);
      check("busy_after_reset", {12'h000, busy_o}, 13'h0001);
   endtask : t_reset
   task automatic t_page;
      // Full page, highest count in one internal write
      for (int i = 0; i < 32; i++) issue(1'b1, i == 31, 13'h0040 + i[12:0], 8'ha5 ^ i[7:0]);
      #1;
      check("page_err_in_page", {12'h000, page_err_o}, 13'h0000);
      for (int i = 0; i < 32; i++) read_chk(13'h0040 + i[12:0], 8'ha5 ^ i[7:0]);
   endtask : t_page
   task automatic t_edge;
      issue(1'b1, 1'b1, 13'h1fff, 8'h3c);
      read_chk(13'h1fff, 8'h3c);
   endtask : t_edge
   task automatic t_cross;
      issue(1'b1, 1'b0, 13'h0060, 8'h11);
      issue(1'b1, 1'b1, 13'h0080, 8'h22);
      repeat (3) @(posedge clock_i);
      #1;
      check("page_err_cross", {12'h000, page_err_o}, 13'h0001);
   endtask : t_cross
   task automatic t_gap;
      // Lone load closed by the idle gap, then the full unpolled write time
      issue(1'b1, 1'b0, 13'h0200, 8'h5a);
      repeat (60) @(posedge clock_i);
      #1;
      check("busy_gap_wait", {12'h000, busy_o}, 13'h0001);
      read_chk(13'h0200, 8'h5a);
   endtask : t_gap
   task automatic t_abort;
      int k;
      issue(1'b1, 1'b1, 13'h0100, 8'h77);
      k = 0;
      while (busy_o !== 1'b1 && k < 200) begin
         @(posedge clock_i);
         #1;
         k++;
      end
      // Reset mid-write must pull the lock and lose the byte
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;
      #1;
      check("lock_in_reset", {12'h000, lock_n}, 13'h0000);
      read_chk(13'h0100, 8'hff);
   endtask : t_abort

   initial begin
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;
      #1;
      t_reset();
      t_page();
      t_edge();
      t_cross();
      t_gap();
      t_abort();
      test_done();
   end
   initial begin
      #400000;
      n_mismatch++;
      test_done();
   end
endmodule : tb_top
`default_nettype wire
